// [hdl/ccti_timer.sv]
`timescale 1ns/1ns
module ccti_timer (
  input  wire logic              clk_sys,
  input  wire logic              arst_n,
  input  wire logic [5:0]        regAddr,
  input  wire logic [15:0]       regWdata,
  input  wire logic              regWr,
  input  wire logic              regRd,
  output logic      [15:0]       regRdata,
  input  wire logic              extCountPin,
  output logic                   timerOutPin,
  output logic                   compareOverflowIrq,
  output logic                   capture0Irq,
  output logic                   capture1Irq
);
  import ccti_pkg::*;

  ccti_state_t  state_ff;
  ccti_state_t  nxt_state;
  ccti_tick_if  tickIf ();
  logic         active;
  logic         tick;
  logic [15:0]  cntNext;
  logic         match0Ev;
  logic         match1Ev;
  logic         load1Ev;
  logic         ovfEv;
  logic         cap0Ev;
  logic         cap1Ev;
  logic         swCapEv;
  logic         flopRise;
  logic         flopFall;
  logic         wrMode;
  logic         wrToggle;

  ccti_tick_gen u_tick (
    .clk_sys     (clk_sys),
    .arst_n      (arst_n),
    .extCountPin (extCountPin),
    .tickIf      (tickIf)
  );

  assign tickIf.clkSel = state_ff.clkSel;
  assign active        = state_ff.en & state_ff.run;
  assign tick          = active & tickIf.countTick;
  assign wrMode        = regWr && regAddr == ADDR_MODE;
  assign wrToggle      = regWr && regAddr == ADDR_TOGGLE;
  assign swCapEv       = wrMode && !regWdata[BIT_SWCAP];
  assign flopRise      = state_ff.flop & ~state_ff.flopPrev;
  assign flopFall      = ~state_ff.flop & state_ff.flopPrev;

  // Counter step: clear on match with compare 1 when enabled, else wrap at the top.
  always_comb begin
    if (state_ff.cle && state_ff.cnt == state_ff.cmp1) begin
      cntNext = WORD_RST;
    end else begin
      cntNext = state_ff.cnt + 16'h0001;
    end
  end

  assign ovfEv    = tick && state_ff.cnt == CNT_MAX
                    && !(state_ff.cle && state_ff.cnt == state_ff.cmp1);
  assign match0Ev = tick && cntNext == state_ff.cmp0;
  assign match1Ev = tick && cntNext == state_ff.cmp1;
  assign load1Ev  = tick && state_ff.cnt == state_ff.cmp1;

  // Capture timing: pin edges or edges of the output flop.
  always_comb begin
    cap0Ev = swCapEv;
    cap1Ev = 1'b0;
    unique case (state_ff.capSel)
      CAP_PIN: begin
        cap0Ev = swCapEv | (active & tickIf.extRise);
        cap1Ev = active & tickIf.extFall;
      end
      CAP_FLOP: begin
        cap0Ev = swCapEv | (active & flopRise);
        cap1Ev = active & flopFall;
      end
      default: begin
        cap0Ev = swCapEv;
        cap1Ev = 1'b0;
      end
    endcase
  end

  always_comb begin
    nxt_state          = state_ff;
    nxt_state.flopPrev = state_ff.flop;
    nxt_state.irqCmp   = match0Ev | match1Ev | ovfEv;
    nxt_state.irqCap0  = cap0Ev;
    nxt_state.irqCap1  = cap1Ev;

    if (!active) begin
      nxt_state.cnt = WORD_RST;
    end else if (tick) begin
      nxt_state.cnt = cntNext;
    end

    if (cap0Ev) begin
      nxt_state.cap0 = state_ff.cnt;
    end
    if (cap1Ev) begin
      nxt_state.cap1 = state_ff.cnt;
    end

    if (state_ff.bufEn && load1Ev) begin
      nxt_state.cmp0 = state_ff.shd0;
      nxt_state.cmp1 = state_ff.shd1;
    end

    if ((match0Ev && state_ff.tglEn[0]) ^ (match1Ev && state_ff.tglEn[1])
        ^ (cap0Ev && state_ff.tglEn[2]) ^ (cap1Ev && state_ff.tglEn[3])) begin
      nxt_state.flop = ~state_ff.flop;
    end

    if (regWr) begin
      unique case (regAddr)
        ADDR_ENABLE: nxt_state.en    = regWdata[BIT_ENABLE];
        ADDR_RUN:    nxt_state.run   = regWdata[BIT_RUN];
        ADDR_CTRL:   nxt_state.bufEn = regWdata[BIT_BUFEN];
        ADDR_MODE: begin
          nxt_state.clkSel = regWdata[POS_CLKSEL +: 2];
          nxt_state.cle    = regWdata[BIT_CLE];
          nxt_state.capSel = regWdata[POS_CAPSEL +: 2];
        end
        ADDR_TOGGLE: begin
          nxt_state.tglEn = regWdata[POS_TGLEN +: 4];
          unique case (regWdata[POS_FLOPCMD +: 2])
            CMD_TOGGLE: nxt_state.flop = ~state_ff.flop;
            CMD_SET:    nxt_state.flop = 1'b1;
            CMD_CLEAR:  nxt_state.flop = 1'b0;
            default:    nxt_state.flop = nxt_state.flop;
          endcase
        end
        ADDR_CMP0: begin
          nxt_state.shd0 = regWdata;
          if (!state_ff.bufEn || !active) begin
            nxt_state.cmp0 = regWdata;
          end
        end
        ADDR_CMP1: begin
          nxt_state.shd1 = regWdata;
          if (!state_ff.bufEn || !active) begin
            nxt_state.cmp1 = regWdata;
          end
        end
        default: nxt_state.en = nxt_state.en;
      endcase
    end

    nxt_state.rdata = WORD_RST;
    if (regRd) begin
      unique case (regAddr)
        ADDR_ENABLE: nxt_state.rdata[BIT_ENABLE] = state_ff.en;
        ADDR_RUN:    nxt_state.rdata[BIT_RUN]    = state_ff.run;
        ADDR_CTRL:   nxt_state.rdata[BIT_BUFEN]  = state_ff.bufEn;
        ADDR_MODE: begin
          nxt_state.rdata[POS_CLKSEL +: 2] = state_ff.clkSel;
          nxt_state.rdata[BIT_CLE]         = state_ff.cle;
          nxt_state.rdata[POS_CAPSEL +: 2] = state_ff.capSel;
          nxt_state.rdata[BIT_SWCAP]       = 1'b1;
        end
        ADDR_TOGGLE: begin
          nxt_state.rdata[POS_FLOPCMD +: 2] = 2'h3;
          nxt_state.rdata[POS_TGLEN +: 4]   = state_ff.tglEn;
        end
        ADDR_CMP0:   nxt_state.rdata = state_ff.cmp0;
        ADDR_CMP1:   nxt_state.rdata = state_ff.cmp1;
        ADDR_CAP0:   nxt_state.rdata = state_ff.cap0;
        ADDR_CAP1:   nxt_state.rdata = state_ff.cap1;
        ADDR_LIVE:   nxt_state.rdata = state_ff.cnt;
        ADDR_STATUS: nxt_state.rdata[0] = state_ff.flop;
        default:     nxt_state.rdata = WORD_RST;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state_ff        <= '0;
      state_ff.clkSel <= CLKSEL_RST;
      state_ff.capSel <= CAPSEL_RST;
      state_ff.tglEn  <= TGLEN_RST;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign regRdata           = state_ff.rdata;
  assign timerOutPin        = state_ff.flop;
  assign compareOverflowIrq = state_ff.irqCmp;
  assign capture0Irq        = state_ff.irqCap0;
  assign capture1Irq        = state_ff.irqCap1;

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  sequence s_stop_write;
    regWr && regAddr == ADDR_RUN && !regWdata[BIT_RUN];
  endsequence

  sequence s_soft_capture;
    regWr && regAddr == ADDR_MODE && !regWdata[BIT_SWCAP];
  endsequence

  a_stop_clears_count: assert property (s_stop_write ##1 1 |=> state_ff.cnt == WORD_RST)
    else $error("Counter not zero after stop.");
  a_overflow_irq_wrap: assert property (tick && state_ff.cnt == CNT_MAX && !state_ff.cle
    |=> compareOverflowIrq && state_ff.cnt == WORD_RST)
    else $error("Overflow did not wrap or interrupt.");
  a_match_irq_pulse: assert property (active && $changed(state_ff.cnt)
    && (state_ff.cnt == state_ff.cmp0 || state_ff.cnt == state_ff.cmp1)
    && $stable(state_ff.cmp0) && $stable(state_ff.cmp1) |-> compareOverflowIrq)
    else $error("Match without compare interrupt.");
  a_shadow_load_match: assert property (state_ff.bufEn && load1Ev && !regWr
    |=> state_ff.cmp0 == $past(state_ff.shd0) && state_ff.cmp1 == $past(state_ff.shd1))
    else $error("Shadow not loaded on match.");
  a_stopped_write_now: assert property (!active && regWr && regAddr == ADDR_CMP0
    |=> state_ff.cmp0 == $past(regWdata))
    else $error("Stopped compare write not immediate.");
  a_buffered_write_held: assert property (active && state_ff.bufEn && regWr && regAddr == ADDR_CMP1
    && !load1Ev |=> state_ff.cmp1 == $past(state_ff.cmp1))
    else $error("Buffered compare write leaked through.");
  a_soft_capture_copy: assert property (s_soft_capture |=>
    state_ff.cap0 == $past(state_ff.cnt) && capture0Irq)
    else $error("Software capture missed.");
  a_live_count_read: assert property (regRd && regAddr == ADDR_LIVE |=> regRdata == $past(state_ff.cnt))
    else $error("Live count read wrong.");
  a_flop_set_cmd: assert property (wrToggle && regWdata[POS_FLOPCMD +: 2] == CMD_SET
    |=> timerOutPin)
    else $error("Flop set command ignored.");
  a_clear_on_match: assert property (tick && state_ff.cle && state_ff.cnt == state_ff.cmp1
    && !(regWr && regAddr == ADDR_RUN) |=> state_ff.cnt == WORD_RST)
    else $error("Clear on match failed.");
  a_match_toggle_flop: assert property (match0Ev && state_ff.tglEn[0] && !match1Ev && !cap0Ev
    && !cap1Ev && !wrToggle |=> timerOutPin != $past(timerOutPin))
    else $error("Match did not invert flop.");
  a_capture1_pin_fall: assert property (active && state_ff.capSel == CAP_PIN && tickIf.extFall
    |=> capture1Irq && state_ff.cap1 == $past(state_ff.cnt))
    else $error("Falling pin capture missed.");

  sequence s_flop_clear_cmd;
    wrToggle && regWdata[POS_FLOPCMD +: 2] == CMD_CLEAR;
  endsequence

  a_stopped_count_zero: assert property (!active
    |=> state_ff.cnt == WORD_RST)
    else $error("Stopped counter not held at zero.");
  a_count_step_wrap: assert property (tick && !(state_ff.cle && state_ff.cnt == state_ff.cmp1)
    |=> state_ff.cnt == $past(state_ff.cnt) + 16'h0001)
    else $error("Counter did not step by one.");
  a_count_hold_idle: assert property (active && !tick
    |=> state_ff.cnt == $past(state_ff.cnt))
    else $error("Counter moved without a tick.");
  a_cmp_irq_quiet: assert property (!(match0Ev || match1Ev || ovfEv)
    |=> !compareOverflowIrq)
    else $error("Compare interrupt without an event.");
  a_match0_irq: assert property (match0Ev
    |=> compareOverflowIrq && state_ff.cnt == $past(state_ff.cmp0))
    else $error("Match with compare value 0 not flagged.");
  a_match1_irq: assert property (match1Ev
    |=> compareOverflowIrq && state_ff.cnt == $past(state_ff.cmp1))
    else $error("Match with compare value 1 not flagged.");
  a_capture0_latch: assert property (cap0Ev
    |=> capture0Irq && state_ff.cap0 == $past(state_ff.cnt))
    else $error("Capture 0 latch or interrupt missed.");
  a_capture0_pin_rise: assert property (active && state_ff.capSel == CAP_PIN && tickIf.extRise
    |=> capture0Irq && state_ff.cap0 == $past(state_ff.cnt))
    else $error("Rising pin capture missed.");
  a_capture1_flop_fall: assert property (active && state_ff.capSel == CAP_FLOP && flopFall
    |=> capture1Irq && state_ff.cap1 == $past(state_ff.cnt))
    else $error("Falling flop capture missed.");
  a_capture1_quiet: assert property (!active || state_ff.capSel == CAP_OFF
    |=> !capture1Irq)
    else $error("Capture 1 interrupt while capture is off.");
  a_flop_clear_cmd: assert property (s_flop_clear_cmd
    |=> !timerOutPin)
    else $error("Flop clear command ignored.");
  a_flop_toggle_cmd: assert property (wrToggle && regWdata[POS_FLOPCMD +: 2] == CMD_TOGGLE
    |=> timerOutPin != $past(timerOutPin))
    else $error("Flop toggle command ignored.");
  a_direct_cmp1_write: assert property (!state_ff.bufEn && regWr && regAddr == ADDR_CMP1
    |=> state_ff.cmp1 == $past(regWdata))
    else $error("Unbuffered compare write not immediate.");
  a_match1_toggle_flop: assert property (match1Ev && state_ff.tglEn[1] && !match0Ev && !cap0Ev
    && !cap1Ev && !wrToggle |=> timerOutPin != $past(timerOutPin))
    else $error("Match with compare value 1 did not invert flop.");
endmodule : ccti_timer

// [hdl/ccti_pkg.sv]
package ccti_pkg;
  localparam int            CNT_W          = 16;
  localparam logic [5:0]    ADDR_ENABLE    = 6'h00;
  localparam logic [5:0]    ADDR_RUN       = 6'h04;
  localparam logic [5:0]    ADDR_CTRL      = 6'h08;
  localparam logic [5:0]    ADDR_MODE      = 6'h0C;
  localparam logic [5:0]    ADDR_TOGGLE    = 6'h10;
  localparam logic [5:0]    ADDR_CMP0      = 6'h14;
  localparam logic [5:0]    ADDR_CMP1      = 6'h18;
  localparam logic [5:0]    ADDR_CAP0      = 6'h1C;
  localparam logic [5:0]    ADDR_CAP1      = 6'h20;
  localparam logic [5:0]    ADDR_LIVE      = 6'h24;
  localparam logic [5:0]    ADDR_STATUS    = 6'h28;
  localparam int            BIT_ENABLE     = 7;
  localparam int            BIT_RUN        = 0;
  localparam int            BIT_BUFEN      = 7;
  localparam int            POS_CLKSEL     = 0;
  localparam int            BIT_CLE        = 2;
  localparam int            POS_CAPSEL     = 3;
  localparam int            BIT_SWCAP      = 5;
  localparam int            POS_FLOPCMD    = 0;
  localparam int            POS_TGLEN      = 2;
  localparam logic [1:0]    CLK_EXT        = 2'h0;
  localparam logic [1:0]    CLK_T1         = 2'h1;
  localparam logic [1:0]    CLK_T4         = 2'h2;
  localparam logic [1:0]    CLK_T16        = 2'h3;
  localparam logic [1:0]    CAP_OFF        = 2'h0;
  localparam logic [1:0]    CAP_PIN        = 2'h1;
  localparam logic [1:0]    CAP_FLOP       = 2'h2;
  localparam logic [1:0]    CMD_TOGGLE     = 2'h0;
  localparam logic [1:0]    CMD_SET        = 2'h1;
  localparam logic [1:0]    CMD_CLEAR      = 2'h2;
  localparam logic [4:0]    PRE_T1_MASK    = 5'h01;
  localparam logic [4:0]    PRE_T4_MASK    = 5'h07;
  localparam logic [4:0]    PRE_T16_MASK   = 5'h1F;
  localparam logic [15:0]   CNT_MAX        = 16'hFFFF;
  localparam logic [1:0]    CLKSEL_RST     = 2'h0;
  localparam logic [1:0]    CAPSEL_RST     = 2'h0;
  localparam logic [3:0]    TGLEN_RST      = 4'h0;
  localparam logic [15:0]   WORD_RST       = 16'h0000;

  typedef struct packed {
    logic              en;
    logic              run;
    logic              bufEn;
    logic [1:0]        clkSel;
    logic              cle;
    logic [1:0]        capSel;
    logic [3:0]        tglEn;
    logic [15:0]       cnt;
    logic [15:0]       cmp0;
    logic [15:0]       cmp1;
    logic [15:0]       shd0;
    logic [15:0]       shd1;
    logic [15:0]       cap0;
    logic [15:0]       cap1;
    logic              flop;
    logic              flopPrev;
    logic              irqCmp;
    logic              irqCap0;
    logic              irqCap1;
    logic [15:0]       rdata;
  } ccti_state_t;

  typedef struct packed {
    logic [4:0]        pre;
    logic              sync1;
    logic              sync2;
    logic              sync3;
  } ccti_tick_state_t;
endpackage : ccti_pkg

// [hdl/ccti_tick_if.sv]
`timescale 1ns/1ns
interface ccti_tick_if;
  logic [1:0] clkSel;
  logic       countTick;
  logic       extRise;
  logic       extFall;
  modport gen  (input clkSel, output countTick, output extRise, output extFall);
  modport core (output clkSel, input countTick, input extRise, input extFall);
endinterface : ccti_tick_if

// [hdl/ccti_tick_gen.sv]
`timescale 1ns/1ns
module ccti_tick_gen (
  input  wire logic   clk_sys,
  input  wire logic   arst_n,
  input  wire logic   extCountPin,
  ccti_tick_if.gen    tickIf
);
  import ccti_pkg::*;

  ccti_tick_state_t state_ff;
  ccti_tick_state_t nxt_state;
  logic             extRise;

  // The first sync stage feeds only the second; edges come from stages two and three.
  always_comb begin
    nxt_state       = state_ff;
    nxt_state.pre   = state_ff.pre + 5'h01;
    nxt_state.sync1 = extCountPin;
    nxt_state.sync2 = state_ff.sync1;
    nxt_state.sync3 = state_ff.sync2;
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign extRise        = state_ff.sync2 & ~state_ff.sync3;
  assign tickIf.extRise = extRise;
  assign tickIf.extFall = ~state_ff.sync2 & state_ff.sync3;

  // Count clock is one of three prescaler taps or the pin's rising edge.
  always_comb begin
    unique case (tickIf.clkSel)
      CLK_EXT: tickIf.countTick = extRise;
      CLK_T1:  tickIf.countTick = (state_ff.pre & PRE_T1_MASK) == PRE_T1_MASK;
      CLK_T4:  tickIf.countTick = (state_ff.pre & PRE_T4_MASK) == PRE_T4_MASK;
      CLK_T16: tickIf.countTick = (state_ff.pre & PRE_T16_MASK) == PRE_T16_MASK;
    endcase
  end

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  a_ext_tick_edge: assert property (tickIf.clkSel == CLK_EXT && tickIf.countTick |->
    $past(extCountPin, 2) && !$past(extCountPin, 3))
    else $error("External tick without a synchronised rising edge.");
  a_t16_tick_rate: assert property (tickIf.clkSel == CLK_T16 && tickIf.countTick
    |=> (tickIf.clkSel != CLK_T16 || !tickIf.countTick) [*8])
    else $error("Slowest prescaler tap ticks too often.");
endmodule : ccti_tick_gen

// [verification/ccti_pin_partner.sv]
`timescale 1ns/1ns
module ccti_pin_partner (
  input  wire logic clk_sys,
  output logic      extCountPin,
  input  wire logic timerOutPin
);
  int   hiWidth = 0;
  int   loWidth = 0;
  int   runLen  = 0;
  logic lastLvl = 1'b0;

  initial extCountPin = 1'b0;

  // Each level is held for four cycles so that the three-flop synchroniser sees it.
  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge clk_sys);
      extCountPin <= 1'b1;
      repeat (4) @(posedge clk_sys);
      extCountPin <= 1'b0;
      repeat (3) @(posedge clk_sys);
    end
  endtask : pulses

  // The load records how many cycles the output pin last stood at each level.
  always @(posedge clk_sys) begin
    if (timerOutPin !== lastLvl) begin
      if (lastLvl === 1'b1) begin
        hiWidth = runLen;
      end else begin
        loWidth = runLen;
      end
      runLen  = 1;
      lastLvl = timerOutPin;
    end else begin
      runLen++;
    end
  end
endmodule : ccti_pin_partner

// [verification/test_compare_capture_timer16.sv]
`timescale 1ns/1ns
module test_compare_capture_timer16;
  import ccti_pkg::*;
  logic        clk_sys   = 1'b0;
  logic        arst_n    = 1'b0;
  logic [5:0]  regAddr   = 6'h00;
  logic [15:0] regWdata  = 16'h0000;
  logic        regWr     = 1'b0;
  logic        regRd     = 1'b0;
  logic [15:0] regRdata;
  logic        extCountPin;
  logic        timerOutPin;
  logic        compareOverflowIrq;
  logic        capture0Irq;
  logic        capture1Irq;
  logic        rdPend    = 1'b0;
  logic [15:0] expQ[$];
  logic [1:0]  cmdArr[3] = '{CMD_SET, CMD_CLEAR, CMD_TOGGLE};
  logic [1:0]  capArr[3] = '{CAP_OFF, CAP_PIN, 2'h3};
  int          fail_count = 0;
  int          num_checks = 0;
  int          cycles     = 0;
  int          cap0Cnt    = 0;
  int          cap1Cnt    = 0;
  int          seed, k, n, m, gap, c0, c1, ev;

  always #5 clk_sys = ~clk_sys;

  ccti_timer u_dut (
    .clk_sys(clk_sys), .arst_n(arst_n), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .extCountPin(extCountPin),
    .timerOutPin(timerOutPin), .compareOverflowIrq(compareOverflowIrq),
    .capture0Irq(capture0Irq), .capture1Irq(capture1Irq)
  );

  ccti_pin_partner u_partner (.clk_sys(clk_sys), .extCountPin(extCountPin), .timerOutPin(timerOutPin));

  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : stop_test

  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk16

  task automatic chkN(input int got, input int exp);
    num_checks++;
    if (got != exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chkN

  function automatic logic [15:0] mv(input logic cle, input logic [1:0] cs, input logic [1:0] ck);
    mv = 16'h0020 | (16'(cle) << BIT_CLE) | (16'(cs) << POS_CAPSEL) | 16'(ck);
  endfunction : mv

  function automatic logic [15:0] tv(input logic [3:0] en, input logic [1:0] cmd);
    tv = (16'(en) << POS_TGLEN) | 16'(cmd);
  endfunction : tv

  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    regAddr  <= a;
    regWdata <= d;
    regWr    <= 1'b1;
    @(posedge clk_sys);
    regWr    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [5:0] a, input logic [15:0] e);
    expQ.push_back(e);
    @(posedge clk_sys);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge clk_sys);
    regRd   <= 1'b0;
    @(posedge clk_sys);
  endtask : rd

  task automatic waitIrq(output int cnt);
    cnt = 0;
    do begin
      @(posedge clk_sys);
      cnt++;
    end while (compareOverflowIrq !== 1'b1 && cnt < 300);
  endtask : waitIrq

  // Read data stand only in the cycle after the strobe; the oldest note is compared then.
  always @(posedge clk_sys) begin
    if (rdPend === 1'b1 && expQ.size() > 0) begin
      chk16(regRdata, expQ.pop_front());
    end
    rdPend <= regRd;
  end

  always @(posedge clk_sys) begin
    cycles++;
    if (capture0Irq === 1'b1) cap0Cnt++;
    if (capture1Irq === 1'b1) cap1Cnt++;
    if (cycles == 20000) begin
      fail_count++;
      stop_test();
    end
  end

  initial begin
    seed = $urandom(80769);
    repeat (3) @(posedge clk_sys);
    arst_n <= 1'b1;
    wr(ADDR_ENABLE, 16'h0080);
    rd(ADDR_LIVE, 16'h0000);
    rd(ADDR_CTRL, 16'h0000);
    rd(ADDR_STATUS, 16'h0000);
    rd(6'h3C, 16'h0000);
    $display("Test reset_values done");

    k = $urandom_range(10, 3);
    wr(ADDR_MODE, mv(1'b0, CAP_OFF, CLK_EXT));
    wr(ADDR_RUN, 16'h0001);
    u_partner.pulses(k);
    repeat (6) @(posedge clk_sys);
    rd(ADDR_LIVE, k[15:0]);
    c0 = cap0Cnt;
    wr(ADDR_MODE, 16'h0000);
    rd(ADDR_CAP0, k[15:0]);
    chkN(cap0Cnt - c0, 1);
    wr(ADDR_RUN, 16'h0000);
    rd(ADDR_LIVE, 16'h0000);
    $display("Test event_counter done");

    n = $urandom_range(9, 2);
    m = $urandom_range(9, 2);
    wr(ADDR_CTRL, 16'h0080);
    wr(ADDR_CMP0, n[15:0]);
    wr(ADDR_CMP1, n[15:0]);
    rd(ADDR_CMP1, n[15:0]);
    wr(ADDR_TOGGLE, 16'h0003);
    wr(ADDR_MODE, mv(1'b1, CAP_OFF, CLK_T1));
    wr(ADDR_RUN, 16'h0001);
    waitIrq(gap);
    waitIrq(gap);
    chkN(gap, 2 * (n + 1));
    wr(ADDR_CMP0, m[15:0]);
    wr(ADDR_CMP1, m[15:0]);
    repeat (6) waitIrq(gap);
    chkN(gap, 2 * (m + 1));
    wr(ADDR_RUN, 16'h0000);
    $display("Test interval_buffered done");

    wr(ADDR_CTRL, 16'h0000);
    wr(ADDR_CMP0, 16'h0001);
    wr(ADDR_CMP1, 16'h0005);
    for (int p = 0; p < 2; p++) begin
      wr(ADDR_TOGGLE, tv(4'h3, (p == 1) ? CMD_SET : CMD_CLEAR));
      wr(ADDR_RUN, 16'h0001);
      repeat (60) @(posedge clk_sys);
      chkN(u_partner.hiWidth, (p == 1) ? 4 : 8);
      chkN(u_partner.loWidth, (p == 1) ? 8 : 4);
      wr(ADDR_RUN, 16'h0000);
    end
    $display("Test pulse_output done");

    for (int i = 0; i < 3; i++) begin
      wr(ADDR_TOGGLE, tv(4'h0, cmdArr[i]));
      rd(ADDR_STATUS, {15'h0000, i != 1});
      chk16({15'h0000, timerOutPin}, {15'h0000, i != 1});
    end
    $display("Test flop_commands done");

    for (int i = 0; i < 3; i++) begin
      ev = (capArr[i] == CAP_PIN) ? 3 : 0;
      wr(ADDR_TOGGLE, tv(4'h4, CMD_CLEAR));
      wr(ADDR_MODE, mv(1'b0, capArr[i], CLK_T1));
      wr(ADDR_RUN, 16'h0001);
      c0 = cap0Cnt;
      c1 = cap1Cnt;
      u_partner.pulses(3);
      repeat (6) @(posedge clk_sys);
      chkN(cap0Cnt - c0, ev);
      chkN(cap1Cnt - c1, ev);
      rd(ADDR_STATUS, {15'h0000, ev != 0});
      wr(ADDR_RUN, 16'h0000);
    end
    $display("Test capture_timing done");

    wr(ADDR_TOGGLE, tv(4'h0, CMD_CLEAR));
    wr(ADDR_CMP0, 16'h0005);
    for (int t = 0; t < 2; t++) begin
      wr(ADDR_MODE, mv(1'b1, CAP_FLOP, (t == 1) ? CLK_T16 : CLK_T4));
      wr(ADDR_RUN, 16'h0001);
      waitIrq(gap);
      waitIrq(gap);
      chkN(gap, 6 * (int'((t == 1) ? PRE_T16_MASK : PRE_T4_MASK) + 1));
      c0 = cap0Cnt;
      c1 = cap1Cnt;
      wr(ADDR_TOGGLE, tv(4'h0, CMD_SET));
      wr(ADDR_TOGGLE, tv(4'h0, CMD_CLEAR));
      repeat (3) @(posedge clk_sys);
      chkN(cap0Cnt - c0, 1);
      chkN(cap1Cnt - c1, 1);
      wr(ADDR_RUN, 16'h0000);
    end
    $display("Test clock_taps done");
    stop_test();
  end
endmodule : test_compare_capture_timer16
